// ===== epd_sequencer.v
// Display controller command interpreter: reset, configuration,
// image memory loading and the full refresh sequence.
// Assumes the host waits for busy low before sending further commands.
`timescale 1ns/1ns
`include "epd_consts.vh"
module epd_sequencer
#(
    parameter MEM_AW = 10                  // Image memory address width.
)
(
    input  wire       i_clk,               // System clock, 25 MHz.
    input  wire       i_rst,               // Asynchronous reset.
    input  wire       i_cs_n,              // Chip select, active low.
    input  wire       i_sclk,              // Link clock from host.
    input  wire       i_sda,               // Link data from host.
    output reg        o_busy,              // Busy, high while working.
    output reg        o_booster_on,        // Booster and regulators on.
    output reg        o_drive,             // Panel drive strobe.
    output reg  [7:0] o_pixel,             // Pixel pair to the panel.
    output reg  [7:0] o_lut,               // Loaded waveform entry.
    output reg  [7:0] o_vcom               // Common voltage setting.
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_SWRST = 3'h1;
    localparam ST_BOOST = 3'h2;
    localparam ST_LUT   = 3'h3;
    localparam ST_DRIVE = 3'h4;
    localparam ST_OFF   = 3'h5;

    wire             rx_valid;
    wire             rx_is_data;
    wire [7:0]       rx_byte;
    reg  [2:0]       state_r;
    reg  [7:0]       cmd_r;
    reg  [7:0]       analog_r;
    reg  [7:0]       digital_r;
    reg  [7:0]       upd_ctrl_r;
    reg  [7:0]       entry_r;
    reg  [MEM_AW-1:0] addr_r;
    reg  [MEM_AW-1:0] scan_r;
    reg  [7:0]       step_r;
    reg  [7:0]       black_white_mem [0:(1<<MEM_AW)-1];
    reg  [7:0]       col_mem  [0:(1<<MEM_AW)-1];
    reg              black_white_we;
    reg              col_we;

    // Places a received byte into the address counter, padded or cut.
    function [MEM_AW-1:0] fit_addr;
        input [7:0]        b;
        reg   [MEM_AW+7:0] wide;
        begin
            wide     = {{MEM_AW{1'b0}}, b};
            fit_addr = wide[MEM_AW-1:0];
        end
    endfunction

    // Next plane address; wraps at the top of the plane.
    function [MEM_AW-1:0] inc_addr;
        input [MEM_AW-1:0] a;
        begin
            inc_addr = a + {{(MEM_AW-1){1'b0}}, 1'b1};
        end
    endfunction

    spi3_rx u_rx
    (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_cs_n    (i_cs_n),
        .i_sclk    (i_sclk),
        .i_sda     (i_sda),
        .o_valid   (rx_valid),
        .o_is_data (rx_is_data),
        .o_byte    (rx_byte)
    );

    // Image planes are written only while the matching command is current.
    always @*
    begin
        black_white_we = rx_valid & rx_is_data
                 & (cmd_r == `CMD_WRITE_BLACK_WHITE)
                 & (state_r == ST_IDLE);
        col_we = rx_valid & rx_is_data & (cmd_r == `CMD_WRITE_COLOUR)
                 & (state_r == ST_IDLE);
    end

    // Plane memories without reset so they map onto block memory.
    always @(posedge i_clk)
    begin
        if (black_white_we)
            black_white_mem[addr_r] <= rx_byte;
        if (col_we)
            col_mem[addr_r] <= rx_byte;
    end

    // Command decoding and the long operation sequencer.
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r      <= ST_IDLE;
            cmd_r        <= 8'h00;
            analog_r     <= `ANALOG_RESET_VAL;
            digital_r    <= `DIGITAL_RESET_VAL;
            upd_ctrl_r   <= `UPD_CTRL_RESET;
            entry_r      <= 8'h00;
            addr_r       <= {MEM_AW{1'b0}};
            scan_r       <= {MEM_AW{1'b0}};
            step_r       <= 8'h00;
            o_busy       <= 1'b0;
            o_booster_on <= 1'b0;
            o_drive      <= 1'b0;
            o_pixel      <= 8'h00;
            o_lut        <= 8'h00;
            o_vcom       <= 8'h00;
        end
        else
        begin
            o_drive <= 1'b0;
            case (state_r)
            ST_IDLE:
            begin
                if (rx_valid && !rx_is_data)
                begin
                    cmd_r <= rx_byte;
                    if (rx_byte == `CMD_SW_RESET)
                    begin
                        o_busy  <= 1'b1;
                        step_r  <= 8'h00;
                        state_r <= ST_SWRST;
                    end
                    else if (rx_byte == `CMD_ACTIVATE)
                    begin
                        o_busy  <= 1'b1;
                        step_r  <= 8'h00;
                        state_r <= ST_BOOST;
                    end
                    else if (rx_byte == `CMD_WRITE_BLACK_WHITE ||
                             rx_byte == `CMD_WRITE_COLOUR)
                        addr_r <= {MEM_AW{1'b0}};
                end
                else if (rx_valid && rx_is_data)
                begin
                    case (cmd_r)
                    `CMD_ANALOG_CTRL:  analog_r   <= rx_byte;
                    `CMD_DIGITAL_CTRL: digital_r  <= rx_byte;
                    `CMD_AC_VCOM:      o_vcom     <= rx_byte;
                    `CMD_UPDATE_CTRL:  upd_ctrl_r <= rx_byte;
                    `CMD_ENTRY_MODE:   entry_r    <= rx_byte;
                    `CMD_X_COUNTER:    addr_r     <= fit_addr(rx_byte);
                    `CMD_WRITE_BLACK_WHITE,
                    `CMD_WRITE_COLOUR: addr_r <= inc_addr(addr_r);
                    default:           cmd_r <= cmd_r;
                    endcase
                end
            end
            ST_SWRST:
            begin
                // Defaults return, then the stored common voltage loads.
                analog_r   <= `ANALOG_RESET_VAL;
                digital_r  <= `DIGITAL_RESET_VAL;
                upd_ctrl_r <= `UPD_CTRL_RESET;
                entry_r    <= 8'h00;
                addr_r     <= {MEM_AW{1'b0}};
                step_r     <= step_r + 8'h01;
                if (step_r == `STEP_CYCLES)
                begin
                    o_vcom  <= `VCOM_OTP_VAL;
                    o_busy  <= 1'b0;
                    state_r <= ST_IDLE;
                end
            end
            ST_BOOST:
            begin
                o_booster_on <= 1'b1;
                step_r       <= step_r + 8'h01;
                if (step_r == `STEP_CYCLES)
                begin
                    step_r  <= 8'h00;
                    state_r <= ST_LUT;
                end
            end
            ST_LUT:
            begin
                o_lut   <= upd_ctrl_r ^ step_r;
                step_r  <= step_r + 8'h01;
                scan_r  <= {MEM_AW{1'b0}};
                if (step_r == `STEP_CYCLES)
                    state_r <= ST_DRIVE;
            end
            ST_DRIVE:
            begin
                // Each pixel combines both planes through the table.
                o_drive <= 1'b1;
                o_pixel <= (black_white_mem[scan_r] & ~col_mem[scan_r])
                           ^ o_lut;
                scan_r  <= inc_addr(scan_r);
                if (scan_r == {MEM_AW{1'b1}})
                    state_r <= ST_OFF;
            end
            ST_OFF:
            begin
                o_booster_on <= 1'b0;
                o_busy       <= 1'b0;
                state_r      <= ST_IDLE;
            end
            default:
                state_r <= ST_IDLE;
            endcase
        end
    end
endmodule

// ===== epd_consts.vh
// Constants for the display controller command sequencer.
// Assumes a 25 MHz system clock and a host-driven three-wire serial link.
`ifndef EPD_CONSTS_VH
`define EPD_CONSTS_VH
`define CMD_SW_RESET      8'h12
`define CMD_ANALOG_CTRL   8'h74
`define CMD_DIGITAL_CTRL  8'h7E
`define CMD_SOFT_START    8'h0C
`define CMD_AC_VCOM       8'h2B
`define CMD_DRV_OUT       8'h01
`define CMD_DUMMY_LINE    8'h3A
`define CMD_GATE_WIDTH    8'h3B
`define CMD_BORDER        8'h3C
`define CMD_ENTRY_MODE    8'h11
`define CMD_X_WINDOW      8'h44
`define CMD_Y_WINDOW      8'h45
`define CMD_X_COUNTER     8'h4E
`define CMD_Y_COUNTER     8'h4F
`define CMD_WRITE_BLACK_WHITE 8'h24
`define CMD_WRITE_COLOUR  8'h26
`define CMD_UPDATE_CTRL   8'h22
`define CMD_ACTIVATE      8'h20
`define ANALOG_RESET_VAL  8'h00
`define DIGITAL_RESET_VAL 8'h00
`define UPD_CTRL_RESET    8'h00
`define VCOM_OTP_VAL      8'h00
`define STEP_CYCLES       8'h10
`endif

// ===== spi3_rx.v
// Three-wire serial receiver: samples the link with the system clock.
// Assumes mode-0 timing; the data/command flag rides as a ninth bit
// sent first in each frame while chip select is low.
`timescale 1ns/1ns
module spi3_rx
(
    input  wire       i_clk,    // System clock.
    input  wire       i_rst,    // Asynchronous reset, active high.
    input  wire       i_cs_n,   // Chip select, active low.
    input  wire       i_sclk,   // Link clock.
    input  wire       i_sda,    // Link data.
    output reg        o_valid,  // One-cycle pulse per received byte.
    output reg        o_is_data,// High for a parameter or data byte.
    output reg  [7:0] o_byte    // Received byte.
);
    reg [2:0] cs_s;
    reg [2:0] sck_s;
    reg [2:0] sda_s;
    reg [3:0] cnt_r;
    reg [8:0] shift_r;
    reg       sck_q;
    reg       cs_q;
    wire      sck_lvl;
    wire      cs_lvl;
    wire      rise;

    // A level counts once the second and third stages agree.
    assign sck_lvl = (sck_s[2] == sck_s[1]) ? sck_s[2] : sck_q;
    assign cs_lvl  = (cs_s[2] == cs_s[1]) ? cs_s[2] : cs_q;
    assign rise    = sck_lvl & ~sck_q & ~cs_lvl;

    // Synchronise, find rising edges, shift in nine bits per frame.
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cs_s      <= 3'h7;
            sck_s     <= 3'h0;
            sda_s     <= 3'h0;
            sck_q     <= 1'b0;
            cs_q      <= 1'b1;
            cnt_r     <= 4'h0;
            shift_r   <= 9'h000;
            o_valid   <= 1'b0;
            o_is_data <= 1'b0;
            o_byte    <= 8'h00;
        end
        else
        begin
            cs_s    <= {cs_s[1:0], i_cs_n};
            sck_s   <= {sck_s[1:0], i_sclk};
            sda_s   <= {sda_s[1:0], i_sda};
            sck_q   <= sck_lvl;
            cs_q    <= cs_lvl;
            o_valid <= 1'b0;
            if (cs_lvl)
                cnt_r <= 4'h0;
            else if (rise)
            begin
                if (cnt_r == 4'h8)
                begin
                    o_valid   <= 1'b1;
                    o_is_data <= shift_r[7];
                    o_byte    <= {shift_r[6:0], sda_s[2]};
                    cnt_r     <= 4'h0;
                end
                else
                    cnt_r <= cnt_r + 4'h1;
                shift_r <= {shift_r[7:0], sda_s[2]};
            end
        end
    end
endmodule

// ===== epd_seq_props.sv
// Checker for busy, booster and panel drive of the command sequencer.
// Assumes it is bound to the sequencer and sees only its ports.
`timescale 1ns/1ns
`include "epd_consts.vh"
module epd_seq_props
#(
    parameter MEM_AW = 10          // Image memory address width.
)
(
    input wire       i_clk,        // System clock.
    input wire       i_rst,        // Asynchronous reset.
    input wire       o_busy,       // Busy flag.
    input wire       o_booster_on, // Booster state.
    input wire       o_drive,      // Drive strobe.
    input wire [7:0] o_vcom        // Common voltage value.
);
    reg [15:0] busy_len_r;         // Cycles of the current busy spell.
    reg [15:0] drv_cnt_r;          // Drive pulses in the spell.
    reg        boost_r;            // Booster seen in the spell.
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Measures each busy spell; everything clears while busy is low.
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst || !o_busy)
        begin
            busy_len_r <= 16'h0000;
            drv_cnt_r  <= 16'h0000;
            boost_r    <= 1'b0;
        end
        else
        begin
            busy_len_r <= busy_len_r + 16'h0001;
            drv_cnt_r  <= drv_cnt_r + {15'h0000, o_drive};
            boost_r    <= boost_r | o_booster_on;
        end
    end
    // A spell ends plainly (software reset) or after a refresh.
    sequence s_spell_end;
        $fell(o_busy);
    endsequence
    sequence s_plain_end;
        s_spell_end ##0 !boost_r;
    endsequence
    sequence s_refresh_end;
        s_spell_end ##0 boost_r;
    endsequence
    a_reset_ready: assert property ($fell(i_rst) |-> !o_busy)
        else $error("busy high right after reset");
    a_swreset_len: assert property (s_plain_end |->
        busy_len_r == `STEP_CYCLES + 8'h01)
        else $error("software reset busy length wrong");
    a_vcom_loaded: assert property (s_plain_end |->
        o_vcom == `VCOM_OTP_VAL)
        else $error("common voltage not reloaded");
    a_boost_in_busy: assert property (o_booster_on |-> o_busy)
        else $error("booster on while not busy");
    a_boost_start: assert property ($rose(o_booster_on) |->
        o_busy ##1 (o_booster_on && !o_drive)[*8])
        else $error("drive before table load");
    a_drive_when_on: assert property (o_drive |-> o_booster_on)
        else $error("drive without booster");
    a_drive_count: assert property (s_refresh_end |->
        drv_cnt_r == (16'h0001 << MEM_AW))
        else $error("drive pulse count wrong");
    a_off_together: assert property ($fell(o_booster_on) |->
        $fell(o_busy))
        else $error("busy and booster did not drop together");
endmodule
bind epd_sequencer epd_seq_props #(.MEM_AW(MEM_AW)) i_epd_seq_props
(
    .i_clk(i_clk),
    .i_rst(i_rst),
    .o_busy(o_busy),
    .o_booster_on(o_booster_on),
    .o_drive(o_drive),
    .o_vcom(o_vcom)
);

// ===== epd_host_model.sv
// Host side of the three-wire link: sends flagged bytes in frames.
// Assumes the system clock paces it; link clock parks low when idle.
`timescale 1ns/1ns
module epd_host_model
(
    input  wire i_clk,             // System clock.
    output reg  o_cs_n,            // Chip select, active low.
    output reg  o_sclk,            // Link clock, 320 ns period.
    output reg  o_sda              // Link data.
);
    // Idle link: deselected, clock parked low.
    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sda  = 1'b0;
    end
    // Sends the flag bit, then the byte MSB first, one bit per period.
    task automatic send(input logic dc, input logic [7:0] b);
        logic [8:0] f;
        f = {dc, b};
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        for (int i = 8; i >= 0; i--)
        begin
            o_sda <= f[i];
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
        repeat (2) @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_sda  <= ~f[0];
        repeat (4) @(posedge i_clk);
    endtask
endmodule

// ===== tb_top.sv
// Testbench for the sequencer: reset, set-up, plane loads and refresh.
// Assumes a 25 MHz clock and the host model driving the link.
`timescale 1ns/1ns
`include "epd_consts.vh"
module tb_top;
    reg        clk = 1'b0;         // System clock.
    reg        rst = 1'b1;         // Reset.
    wire       cs_n, sclk, sda, busy, boost, drive;
    wire [7:0] pixel, lut, vcom;
    int        n_mismatch, comparisons, drives, cycles, spell;
    logic [7:0] pix [0:15];        // Pixels seen on the drive strobes.
    always #20 clk = ~clk;
    epd_host_model i_epd_host_model (.i_clk(clk), .o_cs_n(cs_n),
        .o_sclk(sclk), .o_sda(sda));
    epd_sequencer #(.MEM_AW(4)) i_epd_sequencer (.i_clk(clk), .i_rst(rst),
        .i_cs_n(cs_n), .i_sclk(sclk), .i_sda(sda), .o_busy(busy),
        .o_booster_on(boost), .o_drive(drive), .o_pixel(pixel),
        .o_lut(lut), .o_vcom(vcom));
    // Counts busy cycles and drive pulses, and cuts a hang short.
    always @(posedge clk)
    begin
        if (busy === 1'b1) spell++;
        if (drive === 1'b1)
        begin
            if (drives < 16) pix[drives] = pixel;
            drives++;
        end
        if (++cycles == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    task end_sim();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk1(string n, logic e, logic g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %0h seen %0h", n, e, g);
        end
    endtask
    task chk8(string n, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %0h seen %0h", n, e, g);
        end
    endtask
    task cmd(logic [7:0] b); i_epd_host_model.send(1'b0, b); endtask
    task dat(logic [7:0] b); i_epd_host_model.send(1'b1, b); endtask
    // Waits, bounded, for busy to reach a level, then checks it.
    task wait_busy(logic lvl);
        for (int k = 0; k < 2000 && busy !== lvl; k++) @(negedge clk);
        chk1("busy", lvl, busy);
    endtask
    // Stray data, a voltage value, then software reset and its busy spell.
    task t_sw_reset();
        chk1("busy", 1'b0, busy);
        dat(`CMD_ACTIVATE);
        repeat (20) @(negedge clk);
        chk1("busy", 1'b0, busy);
        cmd(`CMD_AC_VCOM);
        dat(8'h5A);
        repeat (8) @(negedge clk);
        chk8("vcom", 8'h5A, vcom);
        spell = 0;
        cmd(`CMD_SW_RESET);
        wait_busy(1'b1);
        wait_busy(1'b0);
        chk8("busy cycles", `STEP_CYCLES + 8'h01, spell[7:0]);
        chk8("vcom", `VCOM_OTP_VAL, vcom);
    endtask
    // Configuration commands leave the device idle.
    task t_init();
        cmd(`CMD_ANALOG_CTRL);
        dat(8'h54);
        cmd(`CMD_DIGITAL_CTRL);
        dat(8'h3B);
        cmd(`CMD_SOFT_START);
        cmd(`CMD_AC_VCOM);
        cmd(`CMD_DRV_OUT);
        cmd(`CMD_DUMMY_LINE);
        cmd(`CMD_GATE_WIDTH);
        cmd(`CMD_BORDER);
        chk1("booster", 1'b0, boost);
    endtask
    // Window, counters, then one plane of sixteen bytes.
    task t_load(logic [7:0] c, logic [7:0] base);
        cmd(`CMD_ENTRY_MODE);
        cmd(`CMD_X_WINDOW);
        cmd(`CMD_Y_WINDOW);
        cmd(`CMD_X_COUNTER);
        dat(8'h00);
        cmd(`CMD_Y_COUNTER);
        cmd(c);
        for (int i = 0; i < 16; i++) dat(base + i[7:0]);
        chk1("busy", 1'b0, busy);
    endtask
    // Full refresh: busy, booster, one drive pulse per image byte.
    // Pixel differences follow the planes, whatever the table holds.
    task t_refresh();
        logic [7:0] e;
        drives = 0;
        cmd(`CMD_UPDATE_CTRL);
        dat(8'hF7);
        cmd(`CMD_ACTIVATE);
        wait_busy(1'b1);
        wait_busy(1'b0);
        chk8("drive pulses", 8'h10, drives[7:0]);
        for (int i = 1; i < 16; i++)
        begin
            e = (8'h10 + i[7:0]) & ~(8'h0F + i[7:0]);
            chk8("pixel", pix[0] ^ 8'h10 ^ e, pix[i]);
        end
        chk1("booster", 1'b0, boost);
    endtask
    // Main sequence.
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_sw_reset();
        t_init();
        t_load(`CMD_WRITE_BLACK_WHITE, 8'h10);
        t_load(`CMD_WRITE_COLOUR, 8'h0F);
        t_refresh();
        end_sim();
    end
endmodule
